// [sbcs_att_model.sv]
// behavioural model of the requesting attachments on the channel
`timescale 1ns/10ps
module sbcs_att_model
    import sbcs_pkg::*;
(
    // clock and test control
    input wire logic clk,
    input wire logic go,
    input wire logic [7:0] ids,
    input wire logic [7:0] nxfer,
    // channel side
    input wire logic [2:0] code,
    input wire logic control_n,
    input wire logic strobe_n,
    input wire logic hold_n,
    output logic burst_n,
    output logic resp_n,
    output logic csreq_n,
    output sbcs_tag_s tag,
    output logic [ADDR_W-1:0] addr,
    output logic [BUS_W-1:0] bus
);
    logic active = 1'b0;
    logic strobe_q = 1'b1;
    logic [7:0] k = 8'h00;
    logic [BUS_W-1:0] idle_bus = 16'h5AA5;
    initial begin
        burst_n = 1'b1;
        resp_n = 1'b1;
        csreq_n = 1'b1;
    end
    // two-byte writes only, so every strobe moves a full lane pair
    assign tag = '{write: 1'b1, two_byte: 1'b1};
    assign addr = 16'h0100 + {7'h00, k, 1'b0};
    assign bus = active ? {8'hA5, k} : idle_bus;
    always @(posedge clk) begin
        strobe_q <= strobe_n;
        if (go) begin
            burst_n <= 1'b0;
        end
        if (!control_n && code == CBC_SENSE_ID) begin
            idle_bus <= {8'h00, ids};
        end else begin
            // released lines wander instead of holding the last value
            idle_bus <= ~idle_bus;
        end
        if (!control_n && code == CBC_CYCLE_STEAL && !burst_n) begin
            burst_n <= 1'b1;
            resp_n <= 1'b0;
            csreq_n <= 1'b0;
            active <= 1'b1;
            k <= 8'h00;
        end
        // a transfer counts only while grant-hold is held
        if (active && !hold_n && strobe_n && !strobe_q) begin
            k <= k + 8'h01;
            if (k + 8'h01 == nxfer) begin
                resp_n <= 1'b1;
                csreq_n <= 1'b1;
                active <= 1'b0;
            end
        end
    end
endmodule

// [sbcs_mem.sv]
// main storage array, single port, registered read data
`timescale 1ns/10ps
module sbcs_mem
    import sbcs_pkg::*;
(
    // clock
    input wire logic clk,
    // access
    input wire logic en,
    input sbcs_mem_req_s req,
    output logic [BYTE_W-1:0] rdata
);
    logic [BYTE_W-1:0] store [MEM_DEPTH];

    always_ff @(posedge clk) begin
        if (en && req.we) begin
            store[req.addr] <= req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (en && !req.we) begin
            rdata <= store[req.addr];
        end
    end
endmodule

// [sbcs_pkg.sv]
// shared constants and carrier types for the storage bus and cycle steal block
package sbcs_pkg;
    // ======================================================
    // widths
    localparam int BUS_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 16;
    localparam int MEM_DEPTH = 65536;
    localparam int CNT_W = 9;

    // ======================================================
    // command field layout on the system bus (bits 0-7 cmd, 8-15 key)
    localparam int CMD_LSB = 0;
    localparam int KEY_LSB = 8;
    localparam int CMD_WRITE_BIT = 0;

    // ======================================================
    // channel command bus codes
    localparam logic [2:0] CBC_SENSE_ID = 3'h0;
    localparam logic [2:0] CBC_CYCLE_STEAL = 3'h2;
    localparam logic [2:0] CBC_IDLE = 3'h7;

    // ======================================================
    // attachment identifier bits and transfer limit
    localparam int ID_DATA_COMM = 1;
    localparam int ID_DATA_STORAGE = 4;
    localparam int ID_WORK_STATION = 7;
    localparam logic [7:0] ID_MASK = 8'h92;
    localparam logic [CNT_W-1:0] MAX_BURST_BYTES = 9'h100;

    // ======================================================
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int SENSE_SETTLE_NS = 120;
    localparam int SENSE_SETTLE_CYC =
        (SENSE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ======================================================
    // synchroniser lane positions
    localparam int SY_LATCH = 0;
    localparam int SY_CYCLE = 1;
    localparam int SY_BURST = 2;
    localparam int SY_RESP = 3;
    localparam int SY_CSREQ = 4;
    localparam int SY_N = 5;
    localparam logic [SY_N-1:0] SY_RESET = 5'h1F;

    // ======================================================
    // carriers
    typedef struct packed {
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [BYTE_W-1:0] wdata;
    } sbcs_mem_req_s;

    typedef struct packed {
        logic write;
        logic two_byte;
    } sbcs_tag_s;
endpackage

// [sbcs_properties.sv]
// port-level checker for the storage bus and cycle steal block
`timescale 1ns/10ps
module sbcs_props
    import sbcs_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // storage access
    input wire logic ADDR_LATCH_PULSE_N,
    input wire logic STORAGE_CYCLE_N,
    input wire logic SYS_BUS_OE,
    input wire logic STORAGE_DATA_ACK_N,
    input wire logic [BYTE_W-1:0] LAST_COMMAND,
    input wire logic MP_REQ,
    input wire logic MP_GNT,
    // ranking
    input wire logic MACHINE_CHECK,
    input wire logic OTHER_IRQ_REQ,
    input wire logic OTHER_IRQ_GNT,
    input wire logic CP_HALT,
    // channel
    input wire logic BURST_REQ_N,
    input wire logic RESPONSE_N,
    input wire logic CS_REQ_N,
    input wire logic [BUS_W-1:0] TWO_WAY_IN,
    input wire logic [BUS_W-1:0] TWO_WAY_OUT,
    input wire logic [1:0] TWO_WAY_OE,
    input wire logic [2:0] COMMAND_BUS_CODE,
    input wire logic CONTROL_OUT_N,
    input wire logic CHANNEL_STROBE_N,
    input wire logic GRANT_HOLD_N
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);

    // =====================================================
    // helper: identifiers seen during the sense phase
    logic [7:0] ids;
    logic [7:0] win;
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ids <= 8'h00;
        end else if (!CONTROL_OUT_N && COMMAND_BUS_CODE == CBC_SENSE_ID) begin
            ids <= TWO_WAY_IN[7:0] & ID_MASK;
        end
    end
    // lowest set bit is the winner
    assign win = ids & (~ids + 8'h01);

    // =====================================================
    // sequences
    sequence s_sense_strobe;
        (!CONTROL_OUT_N && COMMAND_BUS_CODE == CBC_SENSE_ID &&
            !CHANNEL_STROBE_N) ##1 CHANNEL_STROBE_N;
    endsequence
    sequence s_released;
        STORAGE_DATA_ACK_N && !SYS_BUS_OE;
    endsequence

    // =====================================================
    // assertions
    sense_cmd_a: assert property ($rose(CP_HALT) |-> ##[1:2] s_sense_strobe)
        else $error("sense command not issued after halt");
    strobe_width_a: assert property ($fell(CHANNEL_STROBE_N) |=> CHANNEL_STROBE_N)
        else $error("strobe longer than one cycle");
    grant_lane_a: assert property (TWO_WAY_OE == 2'b10 && !CONTROL_OUT_N |-> COMMAND_BUS_CODE == CBC_CYCLE_STEAL && TWO_WAY_OUT[15:8] == win)
        else $error("wrong select command or winner");
    hold_cause_a: assert property ($fell(GRANT_HOLD_N) |-> !$past(RESPONSE_N, 3) && !$past(CS_REQ_N, 3))
        else $error("grant-hold without response and request");
    hold_end_a: assert property ($rose(RESPONSE_N) |-> ##[1:30] GRANT_HOLD_N)
        else $error("grant-hold not released");
    halt_start_a: assert property ($fell(BURST_REQ_N) && !MACHINE_CHECK && !CP_HALT |-> ##[2:8] CP_HALT)
        else $error("burst request did not halt");
    mc_block_a: assert property ($rose(CP_HALT) |-> !$past(MACHINE_CHECK))
        else $error("burst started under machine check");
    irq_rank_a: assert property (OTHER_IRQ_GNT |-> OTHER_IRQ_REQ && !MACHINE_CHECK && !CP_HALT && GRANT_HOLD_N)
        else $error("other interrupt granted over burst");
    mp_gnt_a: assert property (MP_REQ && !MP_GNT |=> MP_GNT || !MP_REQ)
        else $error("processor storage request starved");
    ack_release_a: assert property ($rose(STORAGE_CYCLE_N) && !STORAGE_DATA_ACK_N |-> ##[2:6] s_released)
        else $error("acknowledge not released");
    read_order_a: assert property ($fell(STORAGE_DATA_ACK_N) && !LAST_COMMAND[CMD_WRITE_BIT] |-> $past(SYS_BUS_OE))
        else $error("read acknowledged before data");
    cmd_capture_a: assert property (!$stable(LAST_COMMAND) |-> !$past(ADDR_LATCH_PULSE_N, 2))
        else $error("command captured without latch pulse");
endmodule

bind sbcs_top sbcs_props u_sbcs_props (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N),
    .ADDR_LATCH_PULSE_N(ADDR_LATCH_PULSE_N),
    .STORAGE_CYCLE_N(STORAGE_CYCLE_N), .SYS_BUS_OE(SYS_BUS_OE),
    .STORAGE_DATA_ACK_N(STORAGE_DATA_ACK_N), .LAST_COMMAND(LAST_COMMAND),
    .MP_REQ(MP_REQ), .MP_GNT(MP_GNT), .MACHINE_CHECK(MACHINE_CHECK),
    .OTHER_IRQ_REQ(OTHER_IRQ_REQ), .OTHER_IRQ_GNT(OTHER_IRQ_GNT),
    .CP_HALT(CP_HALT), .BURST_REQ_N(BURST_REQ_N), .RESPONSE_N(RESPONSE_N),
    .CS_REQ_N(CS_REQ_N), .TWO_WAY_IN(TWO_WAY_IN),
    .TWO_WAY_OUT(TWO_WAY_OUT), .TWO_WAY_OE(TWO_WAY_OE),
    .COMMAND_BUS_CODE(COMMAND_BUS_CODE), .CONTROL_OUT_N(CONTROL_OUT_N),
    .CHANNEL_STROBE_N(CHANNEL_STROBE_N), .GRANT_HOLD_N(GRANT_HOLD_N)
);

// [sbcs_top.sv]
// storage control unit and channel cycle steal sequencer
// ==========================================================
// Overview of operation
// - requester drops latch pulse low with command on bits 0-7, key 8-15
// - storage unit captures command and key while latch pulse is active
// - storage unit latches address once storage cycle is active
// - on read, storage is read, data driven, then acknowledge asserted
// - a burst moves at most 256 bytes without stalling the main processor
// - burst request ranks with cycle steal, below machine check only
// - channel senses identifiers and grants only the highest priority one
// - storage cycles are arbitrated between channel and main processor
// - each transfer strobe moves one or two bytes
// - burst request starts the sequence and halts the control processor
// - channel issues sense command code 000 with command phase and strobe
// - channel then issues cycle steal command code 010
// - channel copies the winning identifier bit onto bits 8-15
// - grant-hold released after attachment drops response or request
`timescale 1ns/10ps
module sbcs_top
    import sbcs_pkg::*;
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET_N,
    // system bus, storage access
    input wire logic ADDR_LATCH_PULSE_N,
    input wire logic STORAGE_CYCLE_N,
    input wire logic [BUS_W-1:0] SYS_BUS_IN,
    output logic [BUS_W-1:0] SYS_BUS_OUT,
    output logic SYS_BUS_OE,
    output logic STORAGE_DATA_ACK_N,
    output logic [BYTE_W-1:0] LAST_COMMAND,
    output logic [BYTE_W-1:0] CONTROL_PROCESSOR_KEY,
    // main processor storage port
    input wire logic MP_REQ,
    input wire logic MP_WE,
    input wire logic [ADDR_W-1:0] MP_ADDR,
    input wire logic [BYTE_W-1:0] MP_WDATA,
    output logic MP_GNT,
    output logic [BYTE_W-1:0] MP_RDATA,
    // interrupt ranking
    input wire logic MACHINE_CHECK,
    input wire logic OTHER_IRQ_REQ,
    output logic OTHER_IRQ_GNT,
    output logic CP_HALT,
    // channel to attachments
    input wire logic BURST_REQ_N,
    input wire logic RESPONSE_N,
    input wire logic CS_REQ_N,
    input sbcs_tag_s ATT_TAG,
    input wire logic [ADDR_W-1:0] ATT_ADDR,
    input wire logic [BUS_W-1:0] TWO_WAY_IN,
    output logic [BUS_W-1:0] TWO_WAY_OUT,
    output logic [1:0] TWO_WAY_OE,
    output logic [2:0] COMMAND_BUS_CODE,
    output logic CONTROL_OUT_N,
    output logic CHANNEL_STROBE_N,
    output logic GRANT_HOLD_N
);
    // ======================================================
    // functions
    function automatic logic [7:0] pick_first(input logic [7:0] ids);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            if (ids[i]) begin
                r = 8'h00;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    // ======================================================
    // pin synchronisers: three stages, change taken when 2 and 3 agree
    logic [SY_N-1:0] sy1, sy2, sy3, syf;
    logic [SY_N-1:0] pins_n;
    assign pins_n = {CS_REQ_N, RESPONSE_N, BURST_REQ_N, STORAGE_CYCLE_N,
        ADDR_LATCH_PULSE_N};

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            sy1 <= SY_RESET;
            sy2 <= SY_RESET;
            sy3 <= SY_RESET;
            syf <= SY_RESET;
        end else begin
            sy1 <= pins_n;
            sy2 <= sy1;
            sy3 <= sy2;
            syf <= (sy2 & ~(sy2 ^ sy3)) | (syf & (sy2 ^ sy3));
        end
    end

    logic latch_on, cycle_on, burst_on, resp_on, csreq_on;
    assign latch_on = !syf[SY_LATCH];
    assign cycle_on = !syf[SY_CYCLE];
    assign burst_on = !syf[SY_BURST];
    assign resp_on = !syf[SY_RESP];
    assign csreq_on = !syf[SY_CSREQ];

    // ======================================================
    // storage arbitration and array
    sbcs_mem_req_s sa_mem, ch_mem, bus_mem, mem_req;
    logic sa_req, ch_req, bus_req, bus_gnt, sa_gnt, ch_gnt;
    logic mp_turn, mem_en;
    logic [BYTE_W-1:0] mem_rdata;

    assign bus_req = sa_req | ch_req;
    assign bus_mem = sa_req ? sa_mem : ch_mem;
    // contested cycles alternate so neither side starves
    assign MP_GNT = MP_REQ && (!bus_req || mp_turn);
    assign bus_gnt = bus_req && !MP_GNT;
    assign sa_gnt = bus_gnt && sa_req;
    assign ch_gnt = bus_gnt && !sa_req;
    assign mem_en = MP_GNT || bus_gnt;
    assign mem_req = MP_GNT ? sbcs_mem_req_s'{MP_WE, MP_ADDR, MP_WDATA}
        : bus_mem;
    assign MP_RDATA = mem_rdata;

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            mp_turn <= 1'b1;
        end else if (MP_REQ && bus_req) begin
            mp_turn <= !mp_turn;
        end
    end

    sbcs_mem u_mem (
        .clk(REF_CLK),
        .en(mem_en),
        .req(mem_req),
        .rdata(mem_rdata)
    );

    // ======================================================
    // single access sequencer
    typedef enum logic [2:0] {
        SA_IDLE, SA_KEYED, SA_ADDRD, SA_WLATCH, SA_WR, SA_RD, SA_RWAIT,
        SA_DONE
    } sbcs_sa_e;
    sbcs_sa_e sa_state;
    logic [ADDR_W-1:0] sa_addr;
    logic [BYTE_W-1:0] sa_wdata;

    assign sa_req = (sa_state == SA_WR) || (sa_state == SA_RD);
    assign sa_mem = '{LAST_COMMAND[CMD_WRITE_BIT], sa_addr, sa_wdata};

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            sa_state <= SA_IDLE;
            sa_addr <= 16'h0000;
            sa_wdata <= 8'h00;
            LAST_COMMAND <= 8'h00;
            CONTROL_PROCESSOR_KEY <= 8'h00;
            SYS_BUS_OUT <= 16'h0000;
            SYS_BUS_OE <= 1'b0;
            STORAGE_DATA_ACK_N <= 1'b1;
        end else begin
            unique case (sa_state)
                SA_IDLE: begin
                    if (latch_on) begin
                        LAST_COMMAND <= SYS_BUS_IN[CMD_LSB +: BYTE_W];
                        CONTROL_PROCESSOR_KEY <= SYS_BUS_IN[KEY_LSB +: BYTE_W];
                        sa_state <= SA_KEYED;
                    end
                end
                SA_KEYED: begin
                    if (cycle_on) begin
                        sa_addr <= SYS_BUS_IN;
                        sa_state <= SA_ADDRD;
                    end else if (!latch_on) begin
                        sa_state <= SA_IDLE;
                    end
                end
                SA_ADDRD: begin
                    // data phase waits for the latch pulse release
                    if (!latch_on) begin
                        sa_state <= LAST_COMMAND[CMD_WRITE_BIT] ? SA_WLATCH
                            : SA_RD;
                    end
                end
                SA_WLATCH: begin
                    sa_wdata <= SYS_BUS_IN[CMD_LSB +: BYTE_W];
                    sa_state <= SA_WR;
                end
                SA_WR: begin
                    if (sa_gnt) begin
                        STORAGE_DATA_ACK_N <= 1'b0;
                        sa_state <= SA_DONE;
                    end
                end
                SA_RD: begin
                    if (sa_gnt) begin
                        sa_state <= SA_RWAIT;
                    end
                end
                SA_RWAIT: begin
                    // data goes out a cycle before the acknowledge
                    SYS_BUS_OUT <= {8'h00, mem_rdata};
                    SYS_BUS_OE <= 1'b1;
                    sa_state <= SA_DONE;
                end
                SA_DONE: begin
                    STORAGE_DATA_ACK_N <= cycle_on ? 1'b0 : 1'b1;
                    if (!cycle_on) begin
                        SYS_BUS_OE <= 1'b0;
                        sa_state <= SA_IDLE;
                    end
                end
            endcase
        end
    end

    // ======================================================
    // channel cycle steal sequencer
    typedef enum logic [2:0] {
        CH_IDLE, CH_SENSE, CH_SENSE_WAIT, CH_GRANT, CH_SELECT, CH_STROBE,
        CH_MEM, CH_RDATA
    } sbcs_ch_e;
    sbcs_ch_e ch_state;
    logic [7:0] ch_ids;
    logic [3:0] wait_cnt;
    logic [CNT_W-1:0] byte_cnt;
    logic [CNT_W-1:0] xfer_len;
    sbcs_tag_s ch_tag;
    logic [ADDR_W-1:0] ch_addr;
    logic [BUS_W-1:0] ch_data;
    logic second;

    assign xfer_len = ATT_TAG.two_byte ? 9'h002 : 9'h001;
    assign ch_req = (ch_state == CH_MEM);
    assign ch_mem = '{ch_tag.write, ch_addr + {15'h0000, second},
        second ? ch_data[15:8] : ch_data[7:0]};
    // burst ranks above other interrupts, machine check above all
    assign OTHER_IRQ_GNT = OTHER_IRQ_REQ && !MACHINE_CHECK
        && !burst_on && (ch_state == CH_IDLE);

    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            ch_state <= CH_IDLE;
            ch_ids <= 8'h00;
            wait_cnt <= 4'h0;
            byte_cnt <= 9'h000;
            ch_tag <= 2'h0;
            ch_addr <= 16'h0000;
            ch_data <= 16'h0000;
            second <= 1'b0;
            CP_HALT <= 1'b0;
            TWO_WAY_OUT <= 16'h0000;
            TWO_WAY_OE <= 2'h0;
            COMMAND_BUS_CODE <= CBC_IDLE;
            CONTROL_OUT_N <= 1'b1;
            CHANNEL_STROBE_N <= 1'b1;
            GRANT_HOLD_N <= 1'b1;
        end else begin
            unique case (ch_state)
                CH_IDLE: begin
                    if (burst_on && !MACHINE_CHECK) begin
                        CP_HALT <= 1'b1;
                        ch_state <= CH_SENSE;
                    end
                end
                CH_SENSE: begin
                    COMMAND_BUS_CODE <= CBC_SENSE_ID;
                    CONTROL_OUT_N <= 1'b0;
                    CHANNEL_STROBE_N <= 1'b0;
                    wait_cnt <= 4'(SENSE_SETTLE_CYC);
                    ch_state <= CH_SENSE_WAIT;
                end
                CH_SENSE_WAIT: begin
                    CHANNEL_STROBE_N <= 1'b1;
                    wait_cnt <= wait_cnt - 4'h1;
                    if (wait_cnt == 4'h1) begin
                        ch_ids <= TWO_WAY_IN[7:0] & ID_MASK;
                        ch_state <= CH_GRANT;
                    end
                end
                CH_GRANT: begin
                    if (ch_ids == 8'h00) begin
                        CONTROL_OUT_N <= 1'b1;
                        COMMAND_BUS_CODE <= CBC_IDLE;
                        CP_HALT <= 1'b0;
                        ch_state <= CH_IDLE;
                    end else begin
                        COMMAND_BUS_CODE <= CBC_CYCLE_STEAL;
                        TWO_WAY_OUT <= {pick_first(ch_ids), 8'h00};
                        TWO_WAY_OE <= 2'h2;
                        ch_state <= CH_SELECT;
                    end
                end
                CH_SELECT: begin
                    if (resp_on && csreq_on) begin
                        CONTROL_OUT_N <= 1'b1;
                        GRANT_HOLD_N <= 1'b0;
                        TWO_WAY_OE <= 2'h0;
                        byte_cnt <= 9'h000;
                        ch_state <= CH_STROBE;
                    end
                end
                CH_STROBE: begin
                    if (!resp_on || !csreq_on) begin
                        // hold released only after the attachment lets go
                        GRANT_HOLD_N <= 1'b1;
                        TWO_WAY_OE <= 2'h0;
                        COMMAND_BUS_CODE <= CBC_IDLE;
                        CP_HALT <= 1'b0;
                        ch_state <= CH_IDLE;
                    end else if (byte_cnt + xfer_len <= MAX_BURST_BYTES) begin
                        CHANNEL_STROBE_N <= 1'b0;
                        ch_tag <= ATT_TAG;
                        ch_addr <= ATT_ADDR;
                        ch_data <= TWO_WAY_IN;
                        second <= 1'b0;
                        TWO_WAY_OE <= 2'h0;
                        ch_state <= CH_MEM;
                    end
                end
                CH_MEM: begin
                    CHANNEL_STROBE_N <= 1'b1;
                    if (ch_gnt) begin
                        byte_cnt <= byte_cnt + 9'h001;
                        if (!ch_tag.write) begin
                            ch_state <= CH_RDATA;
                        end else if (ch_tag.two_byte && !second) begin
                            second <= 1'b1;
                        end else begin
                            ch_state <= CH_STROBE;
                        end
                    end
                end
                CH_RDATA: begin
                    if (second) begin
                        TWO_WAY_OUT[15:8] <= mem_rdata;
                        TWO_WAY_OE[1] <= 1'b1;
                    end else begin
                        TWO_WAY_OUT[7:0] <= mem_rdata;
                        TWO_WAY_OE[0] <= 1'b1;
                    end
                    if (ch_tag.two_byte && !second) begin
                        second <= 1'b1;
                        ch_state <= CH_MEM;
                    end else begin
                        ch_state <= CH_STROBE;
                    end
                end
            endcase
        end
    end
endmodule

// [tb_storage_bus_and_cycle_steal.sv]
// self-checking testbench for the storage bus and cycle steal block
`timescale 1ns/10ps
module tb_storage_bus_and_cycle_steal
    import sbcs_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic latch_n = 1'b1;
    logic cyc_n = 1'b1;
    logic [BUS_W-1:0] sys_drv = 16'h0000;
    logic mp_req = 1'b0;
    logic mp_we = 1'b0;
    logic [ADDR_W-1:0] mp_addr = 16'h0000;
    logic [BYTE_W-1:0] mp_wd = 8'h00;
    logic mc = 1'b0;
    logic go = 1'b0;
    logic [7:0] ids = 8'h00;
    logic [7:0] nx = 8'h01;
    logic [BUS_W-1:0] sys_in, sys_out, tw_in, tw_out, att_bus, att_addr;
    logic [7:0] cmd, key, mp_rd;
    logic sys_oe, ack_n, mp_gnt, irq_gnt, halt, burst_n, resp_n, csreq_n;
    logic ctl_n, strb_n, hold_n;
    logic [1:0] tw_oe;
    logic [2:0] cbc;
    sbcs_tag_s att_tag;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;

    // =====================================================
    // clock, wires and instances
    initial begin
        forever #20 clk = ~clk;
    end
    assign sys_in = sys_oe ? sys_out : sys_drv;
    assign tw_in[15:8] = tw_oe[1] ? tw_out[15:8] : att_bus[15:8];
    assign tw_in[7:0] = tw_oe[0] ? tw_out[7:0] : att_bus[7:0];
    sbcs_top u_sbcs_top (.REF_CLK(clk), .RESET_N(rst_n),
        .ADDR_LATCH_PULSE_N(latch_n), .STORAGE_CYCLE_N(cyc_n),
        .SYS_BUS_IN(sys_in), .SYS_BUS_OUT(sys_out), .SYS_BUS_OE(sys_oe),
        .STORAGE_DATA_ACK_N(ack_n), .LAST_COMMAND(cmd),
        .CONTROL_PROCESSOR_KEY(key), .MP_REQ(mp_req), .MP_WE(mp_we),
        .MP_ADDR(mp_addr), .MP_WDATA(mp_wd), .MP_GNT(mp_gnt),
        .MP_RDATA(mp_rd), .MACHINE_CHECK(mc), .OTHER_IRQ_REQ(1'b1),
        .OTHER_IRQ_GNT(irq_gnt), .CP_HALT(halt), .BURST_REQ_N(burst_n),
        .RESPONSE_N(resp_n), .CS_REQ_N(csreq_n), .ATT_TAG(att_tag),
        .ATT_ADDR(att_addr), .TWO_WAY_IN(tw_in), .TWO_WAY_OUT(tw_out),
        .TWO_WAY_OE(tw_oe), .COMMAND_BUS_CODE(cbc), .CONTROL_OUT_N(ctl_n),
        .CHANNEL_STROBE_N(strb_n), .GRANT_HOLD_N(hold_n));
    sbcs_att_model u_sbcs_att_model (.clk(clk), .go(go), .ids(ids),
        .nxfer(nx), .code(cbc), .control_n(ctl_n), .strobe_n(strb_n),
        .hold_n(hold_n), .burst_n(burst_n), .resp_n(resp_n),
        .csreq_n(csreq_n), .tag(att_tag), .addr(att_addr), .bus(att_bus));

    // =====================================================
    // shared tasks
    task automatic check(input bit ok, input string msg);
        samples_checked++;
        if (!ok) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one single-byte access; a read expects d
    task automatic sto(input bit we, input logic [15:0] a,
            input logic [7:0] d);
        int n;
        @(posedge clk);
        latch_n <= 1'b0;
        sys_drv <= {8'h5A, 7'h20, we};
        repeat (6) @(posedge clk);
        cyc_n <= 1'b0;
        sys_drv <= a;
        repeat (6) @(posedge clk);
        latch_n <= 1'b1;
        sys_drv <= we ? {8'h00, d} : ~a;
        for (n = 0; n < 40 && ack_n !== 1'b0; n++) @(negedge clk);
        check(ack_n === 1'b0, "no acknowledge");
        check(cmd === {7'h20, we} && key === 8'h5A, "command/key");
        if (!we) check(sys_oe === 1'b1 && sys_out === {8'h00, d}, "rdata");
        @(posedge clk);
        cyc_n <= 1'b1;
        sys_drv <= ~sys_drv;
        for (n = 0; n < 40 && ack_n !== 1'b1; n++) @(negedge clk);
        check(ack_n === 1'b1 && sys_oe === 1'b0, "ack not released");
    endtask

    // =====================================================
    // scenarios
    task automatic t_single();
        logic [15:0] a [3] = '{16'h0000, 16'hFFFF, 16'h1234};
        logic [7:0] d [3] = '{8'h5C, 8'hA7, 8'h81};
        for (int i = 0; i < 3; i++) sto(1'b1, a[i], d[i]);
        for (int i = 0; i < 3; i++) sto(1'b0, a[i], d[i]);
    endtask

    // processor port writes on while the bus side writes
    task automatic t_contend();
        int n;
        @(posedge clk);
        mp_req <= 1'b1;
        mp_we <= 1'b1;
        mp_addr <= 16'h0300;
        mp_wd <= 8'h3C;
        sto(1'b1, 16'h0301, 8'hC3);
        @(posedge clk) mp_req <= 1'b0;
        sto(1'b0, 16'h0300, 8'h3C);
        @(posedge clk);
        mp_req <= 1'b1;
        mp_we <= 1'b0;
        mp_addr <= 16'h0301;
        for (n = 0; n < 20 && mp_gnt !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        mp_req <= 1'b0;
        @(negedge clk);
        check(mp_rd === 8'hC3, "processor read");
    endtask

    task automatic t_burst(input logic [7:0] id, input logic [7:0] n,
            input bit mchk);
        int i;
        logic [7:0] win;
        win = 8'h00;
        @(posedge clk);
        ids <= id;
        nx <= n;
        mc <= mchk;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        if (mchk) begin
            repeat (10) @(negedge clk);
            check(halt === 1'b0 && irq_gnt === 1'b0, "halt under mc");
            @(posedge clk);
            mc <= 1'b0;
        end
        for (i = 0; i < 200 && hold_n !== 1'b0; i++) begin
            @(negedge clk);
            if (tw_oe === 2'b10 && ctl_n === 1'b0) win = tw_out[15:8];
        end
        check(halt === 1'b1 && hold_n === 1'b0 && !irq_gnt, "hold");
        check(win === (id & (~id + 8'h01)), "wrong winner");
        for (i = 0; i < 400 && (hold_n !== 1'b1 || halt !== 1'b0); i++)
            @(negedge clk);
        check(hold_n && !halt && irq_gnt === 1'b1, "burst not ended");
        for (i = 0; i < n; i++) begin
            sto(1'b0, 16'(16'h0100 + 2 * i), i[7:0]);
            sto(1'b0, 16'(16'h0101 + 2 * i), 8'hA5);
        end
    endtask

    // =====================================================
    // main sequence and hang guard
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_single();
        t_contend();
        t_burst(8'h92, 8'h03, 1'b1);
        t_burst(8'h90, 8'h02, 1'b0);
        t_burst(8'h80, 8'h01, 1'b0);
        summarize();
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end
endmodule
